// ===== rtl/mrs_shadow_pkg.sv
// constants, field layout and carrier types for the mode register shadow
// assumes word addressing on the debug port, one 32-bit word per address
package mrs_shadow_pkg;

  // debug port geometry
  localparam int DBG_AW = 10;
  localparam int DBG_DW = 32;

  // register word addresses
  localparam logic [9:0] ADDR_MODE01 = 10'h005;
  localparam logic [9:0] ADDR_MODE23 = 10'h006;
  localparam logic [9:0] ADDR_CALCTL = 10'h100;

  // field positions, first mode word
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int WR_LSB = 9;
  localparam int PD_BIT = 12;
  localparam int AL_LSB = 19;

  // field positions, second mode word
  localparam int CWL_LSB = 3;

  // calibration control word bits
  localparam int CAL_OK_BIT = 0;
  localparam int CAL_FAIL_BIT = 1;
  localparam int CAL_REQ_BIT = 2;

  // burst length eight, in its mode register encoding
  localparam logic [2:0] BL_FIXED = 3'h0;

  // writable bits; everything else reads fixed or zero
  localparam logic [31:0] W0_WMASK = 32'h1FFF0F70;
  localparam logic [31:0] W1_WMASK = 32'h000706F8;
  // pass-through bits (writable minus latency fields)
  localparam logic [31:0] W0_PASS = 32'h1FC70100;
  localparam logic [31:0] W1_PASS = 32'h000706C0;
  localparam logic [31:0] W0_FIXED = {29'h0, BL_FIXED};

  // latency defaults used when nothing else is chosen
  localparam logic [2:0] CL_DEF = 3'h2;
  localparam logic [2:0] WR_DEF = 3'h2;
  localparam logic [2:0] AL_DEF = 3'h0;
  localparam logic [2:0] CWL_DEF = 3'h0;

  // index of the last mode register set command per calibration
  localparam logic [1:0] MRS_LAST = 2'h3;

  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] val;
  } mrs_cmd_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_SEND = 2'b10
  } seq_state_t;

endpackage : mrs_shadow_pkg

// ===== rtl/mrs_cal_ctrl.sv
// calibration request bit and its trigger pulse
// assumes the caller qualifies wr_en with address decode and stall
`timescale 1ns/1ps
`default_nettype none
module mrs_cal_ctrl
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register write
  input wire logic wr_en_i,
  input wire logic req_bit_i,
  // towards the physical layer and the sequencer
  output logic cal_req_o,
  output logic start_o
);
  import mrs_shadow_pkg::*;

  logic req_q;
  logic start_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      req_q <= 1'b0;
    else if (wr_en_i)
      req_q <= req_bit_i;
  end

  // the falling request is what launches calibration
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      start_q <= 1'b0;
    else
      start_q <= wr_en_i & req_q & ~req_bit_i;
  end

  assign cal_req_o = req_q;
  assign start_o = start_q;

endmodule : mrs_cal_ctrl
`default_nettype wire

// ===== rtl/mrs_issuer.sv
// sends the four mode register set commands in init order 2,3,1,0
// assumes the mode words hold still while busy_o is high
`timescale 1ns/1ps
`default_nettype none
module mrs_issuer
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // trigger and contents
  input wire logic start_i,
  input wire logic [31:0] word0_i,
  input wire logic [31:0] word1_i,
  // command handshake
  input wire logic ready_i,
  output logic valid_o,
  output mrs_shadow_pkg::mrs_cmd_t cmd_o,
  output logic busy_o
);
  import mrs_shadow_pkg::*;

  seq_state_t state_q;
  logic [1:0] idx_q;
  mrs_cmd_t cmd_q;

  function automatic mrs_cmd_t pick(input logic [1:0] i, input logic [31:0] w0, input logic [31:0] w1);
    mrs_cmd_t c;
    c.sel = 2'h0;
    c.val = 16'h0000;
    case (i)
      2'h0: c = '{sel: 2'h2, val: w1[15:0]};
      2'h1: c = '{sel: 2'h3, val: w1[31:16]};
      2'h2: c = '{sel: 2'h1, val: w0[31:16]};
      default: c = '{sel: 2'h0, val: w0[15:0]};
    endcase
    return c;
  endfunction : pick

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SEQ_IDLE;
      idx_q <= 2'h0;
      cmd_q <= '0;
    end
    else
    begin
      case (state_q)
        SEQ_IDLE:
          if (start_i)
          begin
            state_q <= SEQ_SEND;
            idx_q <= 2'h0;
            cmd_q <= pick(2'h0, word0_i, word1_i);
          end
        SEQ_SEND:
          if (ready_i)
          begin
            if (idx_q == MRS_LAST)
              state_q <= SEQ_IDLE;
            idx_q <= idx_q + 2'h1;
            cmd_q <= pick(idx_q + 2'h1, word0_i, word1_i);
          end
        default:
          state_q <= SEQ_IDLE;
      endcase
    end
  end

  assign valid_o = (state_q == SEQ_SEND);
  assign busy_o = (state_q != SEQ_IDLE);
  assign cmd_o = cmd_q;

endmodule : mrs_issuer
`default_nettype wire

// ===== rtl/ddr3_mode_register_shadow.sv
// mode register shadow words on the debug slave port, with calibration
// trigger and mode register set issue
// assumes host logic mirrors latencies into the timing register itself
//
// Functional notes
// - burst length field fixed, writes ignored
// - burst type and power-down bits read zero
// - writable CAS latency, generated reset value
// - writable write recovery, generated reset value
// - writable additive latency, generated reset value
// - writable CAS write latency, generated reset value
// - first word pass-through bits stored, reset zero
// - second word pass-through bits stored, reset zero
// - reserved bits of both words read zero
// - words live at 0x005 and 0x006
// - request bit one asserts, zero written while it is one starts calibration
`timescale 1ns/1ps
`default_nettype none
module ddr3_mode_register_shadow
#(
  parameter logic [2:0] CAS_LATENCY = mrs_shadow_pkg::CL_DEF,
  parameter logic [2:0] WRITE_RECOVERY = mrs_shadow_pkg::WR_DEF,
  parameter logic [2:0] ADDITIVE_LATENCY = mrs_shadow_pkg::AL_DEF,
  parameter logic [2:0] CAS_WRITE_LATENCY = mrs_shadow_pkg::CWL_DEF
)
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  // debug slave port
  input wire logic [mrs_shadow_pkg::DBG_AW-1:0] DBG_ADDR_I,
  input wire logic DBG_CS_I,
  input wire logic DBG_WR_I,
  input wire logic [mrs_shadow_pkg::DBG_DW-1:0] DBG_WR_DATA_I,
  input wire logic DBG_RD_I,
  output logic [mrs_shadow_pkg::DBG_DW-1:0] DBG_RD_DATA_O,
  output logic DBG_WAITREQUEST_O,
  // physical layer calibration
  input wire logic CAL_SUCCESS_I,
  input wire logic CAL_FAIL_I,
  output logic CAL_REQ_O,
  // mode register set commands
  input wire logic MRS_READY_I,
  output logic MRS_VALID_O,
  output mrs_shadow_pkg::mrs_cmd_t MRS_CMD_O
);
  import mrs_shadow_pkg::*;

  localparam logic [31:0] W0_RESET = W0_FIXED
    | (32'(CAS_LATENCY) << CL_LSB)
    | (32'(WRITE_RECOVERY) << WR_LSB)
    | (32'(ADDITIVE_LATENCY) << AL_LSB);
  localparam logic [31:0] W1_RESET = 32'(CAS_WRITE_LATENCY) << CWL_LSB;

  logic [31:0] mode0_q;
  logic [31:0] mode1_q;
  logic [31:0] rd_data_q;
  logic rd_pend_q;
  logic busy;
  logic cal_start;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_mux;
  logic wr_block;
  logic wr_wait;

  function automatic logic hit(input logic [DBG_AW-1:0] a, input logic [9:0] r);
    return a == DBG_AW'(r);
  endfunction : hit

  // writes stall while commands are going out, so the words sent stay coherent;
  // the start cycle counts too, since the first command is latched from the words then
  assign wr_block = busy | cal_start;
  assign wr_take = DBG_CS_I & DBG_WR_I & ~wr_block;
  // one wait cycle on reads lets the read data come from a flop
  assign rd_take = DBG_CS_I & DBG_RD_I & ~rd_pend_q;
  assign wr_wait = DBG_CS_I & DBG_WR_I & wr_block;
  assign DBG_WAITREQUEST_O = rd_take | wr_wait;

  // writable bits are stored with the fixed ones ORed in on write; reads return the word as stored
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      mode0_q <= W0_RESET;
    else if (wr_take && hit(DBG_ADDR_I, ADDR_MODE01))
      mode0_q <= (DBG_WR_DATA_I & W0_WMASK) | W0_FIXED;
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      mode1_q <= W1_RESET;
    else if (wr_take && hit(DBG_ADDR_I, ADDR_MODE23))
      mode1_q <= DBG_WR_DATA_I & W1_WMASK;
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (hit(DBG_ADDR_I, ADDR_MODE01))
      rd_mux = mode0_q;
    else if (hit(DBG_ADDR_I, ADDR_MODE23))
      rd_mux = mode1_q;
    else if (hit(DBG_ADDR_I, ADDR_CALCTL))
    begin
      rd_mux[CAL_OK_BIT] = CAL_SUCCESS_I;
      rd_mux[CAL_FAIL_BIT] = CAL_FAIL_I;
      rd_mux[CAL_REQ_BIT] = CAL_REQ_O;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      rd_pend_q <= 1'b0;
    else
      rd_pend_q <= rd_take;
  end

  // unmapped addresses answer zero
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      rd_data_q <= 32'h00000000;
    else if (rd_take)
      rd_data_q <= rd_mux;
  end

  assign DBG_RD_DATA_O = rd_data_q;

  // host is expected to leave this alone until a result flag shows
  mrs_cal_ctrl u_cal
  (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .wr_en_i(wr_take && hit(DBG_ADDR_I, ADDR_CALCTL)),
    .req_bit_i(DBG_WR_DATA_I[CAL_REQ_BIT]),
    .cal_req_o(CAL_REQ_O),
    .start_o(cal_start)
  );

  mrs_issuer u_issue
  (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .start_i(cal_start),
    .word0_i(mode0_q),
    .word1_i(mode1_q),
    .ready_i(MRS_READY_I),
    .valid_o(MRS_VALID_O),
    .cmd_o(MRS_CMD_O),
    .busy_o(busy)
  );

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);

  logic wr0;
  logic wr1;
  logic wrc;
  assign wr0 = wr_take && hit(DBG_ADDR_I, ADDR_MODE01);
  assign wr1 = wr_take && hit(DBG_ADDR_I, ADDR_MODE23);
  assign wrc = wr_take && hit(DBG_ADDR_I, ADDR_CALCTL);

  a_bl_fixed_read: assert property (
    rd_take && hit(DBG_ADDR_I, ADDR_MODE01) |=> DBG_RD_DATA_O[2:0] == BL_FIXED && !DBG_WAITREQUEST_O)
    else $error("burst length field not fixed");

  a_bt_pd_zero: assert property (
    wr0 |=> mode0_q[BT_BIT] == 1'b0 && mode0_q[PD_BIT] == 1'b0)
    else $error("burst type or power-down bit stored");

  a_cl_stored: assert property (
    wr0 |=> mode0_q[CL_LSB +: 3] == $past(DBG_WR_DATA_I[CL_LSB +: 3]))
    else $error("CAS latency not stored");

  a_wrec_stored: assert property (
    wr0 ##1 !wr0 |=> mode0_q[WR_LSB +: 3] == $past(DBG_WR_DATA_I[WR_LSB +: 3], 2))
    else $error("write recovery not held");

  a_al_stored: assert property (
    wr0 |=> mode0_q[AL_LSB +: 3] == $past(DBG_WR_DATA_I[AL_LSB +: 3]))
    else $error("additive latency not stored");

  a_cwl_stored: assert property (
    wr1 |=> mode1_q[CWL_LSB +: 3] == $past(DBG_WR_DATA_I[CWL_LSB +: 3]))
    else $error("CAS write latency not stored");

  a_pass0_stored: assert property (
    wr0 |=> (mode0_q & W0_PASS) == ($past(DBG_WR_DATA_I) & W0_PASS))
    else $error("first word pass-through lost");

  a_pass1_stored: assert property (
    wr1 |=> (mode1_q & W1_PASS) == ($past(DBG_WR_DATA_I) & W1_PASS))
    else $error("second word pass-through lost");

  a_rsvd_read_zero: assert property (
    rd_take && hit(DBG_ADDR_I, ADDR_MODE23) |=> (DBG_RD_DATA_O & ~W1_WMASK) == 32'h00000000)
    else $error("reserved bits not zero");

  a_read_one_wait: assert property (
    rd_take |-> DBG_WAITREQUEST_O ##1 (rd_pend_q && !DBG_WAITREQUEST_O))
    else $error("read answer not after one wait");

  a_calreq_follows: assert property (
    wrc |=> CAL_REQ_O == $past(DBG_WR_DATA_I[CAL_REQ_BIT]))
    else $error("calibration request not following write");

  a_mrs_launch: assert property (
    cal_start |=> MRS_VALID_O && MRS_CMD_O.sel == 2'h2 && MRS_CMD_O.val == mode1_q[15:0])
    else $error("mode commands not launched");

  a_wr_stall_busy: assert property (
    busy && DBG_CS_I && DBG_WR_I |-> DBG_WAITREQUEST_O)
    else $error("write taken while commands issue");

  a_wr_stall_start: assert property (
    cal_start && DBG_CS_I && DBG_WR_I |-> DBG_WAITREQUEST_O)
    else $error("write taken in the start cycle");

  a_wr_no_wait_idle: assert property (
    DBG_CS_I && DBG_WR_I && !DBG_RD_I && !busy && !cal_start |-> !DBG_WAITREQUEST_O)
    else $error("idle write stalled");

  // stored contents
  a_fixed_bits_hold: assert property (
    mode0_q[2:0] == BL_FIXED && mode0_q[BT_BIT] == 1'b0 && mode0_q[PD_BIT] == 1'b0)
    else $error("fixed bits of first word moved");

  a_rsvd_store_zero: assert property (
    (mode0_q & ~(W0_WMASK | W0_FIXED)) == 32'h00000000 && (mode1_q & ~W1_WMASK) == 32'h00000000)
    else $error("reserved bits stored");

  a_words_hold: assert property (
    !wr0 && !wr1 |=> $stable(mode0_q) && $stable(mode1_q))
    else $error("mode word changed without a write");

  // debug port answers
  a_rsvd0_read_zero: assert property (
    rd_take && hit(DBG_ADDR_I, ADDR_MODE01) |=> (DBG_RD_DATA_O & ~(W0_WMASK | W0_FIXED)) == 32'h00000000)
    else $error("first word reserved bits not zero");

  a_unmapped_zero: assert property (
    rd_take && !hit(DBG_ADDR_I, ADDR_MODE01) && !hit(DBG_ADDR_I, ADDR_MODE23) && !hit(DBG_ADDR_I, ADDR_CALCTL)
    |=> DBG_RD_DATA_O == 32'h00000000)
    else $error("unmapped read not zero");

  a_rd_data_hold: assert property (
    !rd_take |=> $stable(DBG_RD_DATA_O))
    else $error("read data moved without a read");

  // calibration control
  a_calreq_read: assert property (
    rd_take && hit(DBG_ADDR_I, ADDR_CALCTL)
    |=> DBG_RD_DATA_O == $past({29'h00000000, CAL_REQ_O, CAL_FAIL_I, CAL_SUCCESS_I}))
    else $error("calibration status read wrong");

  a_start_on_fall: assert property (
    wrc && CAL_REQ_O && !DBG_WR_DATA_I[CAL_REQ_BIT] |=> cal_start && !CAL_REQ_O)
    else $error("falling request did not start calibration");

  a_start_needs_fall: assert property (
    cal_start |-> $past(wrc) && $past(CAL_REQ_O) && !CAL_REQ_O)
    else $error("calibration started without a falling request");

  a_cal_req_hold: assert property (
    !wrc |=> $stable(CAL_REQ_O))
    else $error("calibration request moved without a write");

  // command issue order
  a_mrs_no_spurious: assert property (
    MRS_VALID_O && !$past(MRS_VALID_O) |-> $past(cal_start))
    else $error("commands issued without a start");

  a_mrs_hold: assert property (
    MRS_VALID_O && !MRS_READY_I |=> MRS_VALID_O && $stable(MRS_CMD_O))
    else $error("command changed while stalled");

  a_mrs_second: assert property (
    MRS_VALID_O && MRS_READY_I && MRS_CMD_O.sel == 2'h2
    |=> MRS_VALID_O && MRS_CMD_O.sel == 2'h3 && MRS_CMD_O.val == mode1_q[31:16])
    else $error("second command wrong");

  a_mrs_third: assert property (
    MRS_VALID_O && MRS_READY_I && MRS_CMD_O.sel == 2'h3
    |=> MRS_VALID_O && MRS_CMD_O.sel == 2'h1 && MRS_CMD_O.val == mode0_q[31:16])
    else $error("third command wrong");

  a_mrs_fourth: assert property (
    MRS_VALID_O && MRS_READY_I && MRS_CMD_O.sel == 2'h1
    |=> MRS_VALID_O && MRS_CMD_O.sel == 2'h0 && MRS_CMD_O.val == mode0_q[15:0])
    else $error("fourth command wrong");

  a_mrs_end: assert property (
    MRS_VALID_O && MRS_READY_I && MRS_CMD_O.sel == 2'h0 |=> !MRS_VALID_O)
    else $error("command issue did not stop");

  c_mode_write: cover property (wr0 ##1 wr1);
  c_cal_cycle: cover property (wrc && DBG_WR_DATA_I[CAL_REQ_BIT] ##[1:20] cal_start);
  c_mrs_done: cover property (MRS_VALID_O && MRS_READY_I ##1 !MRS_VALID_O);
  c_write_stall: cover property (busy && DBG_CS_I && DBG_WR_I);
  c_cal_status_read: cover property (rd_take && hit(DBG_ADDR_I, ADDR_CALCTL));

endmodule : ddr3_mode_register_shadow
`default_nettype wire

// ===== test/host_model.sv
// host side of the debug slave port: word writes and reads
// assumes a combinational stall flag and a one-cycle read wait
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // clock
  input wire logic clk_i,
  // debug master side
  output logic [mrs_shadow_pkg::DBG_AW-1:0] addr_o,
  output logic cs_o,
  output logic wr_o,
  output logic [mrs_shadow_pkg::DBG_DW-1:0] wdata_o,
  output logic rd_o,
  input wire logic [mrs_shadow_pkg::DBG_DW-1:0] rdata_i,
  input wire logic wait_i
);
  initial
  begin
    addr_o = 10'h000;
    cs_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0;
    rd_o = 1'b0;
  end

  // registers are reached only through this port
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    cs_o <= 1'b1;
    wr_o <= 1'b1;
    do @(posedge clk_i); while (wait_i !== 1'b0);
    cs_o <= 1'b0;
    wr_o <= 1'b0;
    // released lines must not keep showing the last value
    wdata_o <= ~d;
    addr_o <= ~a;
  endtask : bus_wr

  task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    cs_o <= 1'b1;
    rd_o <= 1'b1;
    do @(posedge clk_i); while (wait_i !== 1'b0);
    d = rdata_i;
    cs_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
  endtask : bus_rd
endmodule : host_model
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the mode register shadow
// assumes host_model for bus cycles; the bench plays the phy side
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mrs_shadow_pkg::*;
  localparam logic [2:0] CL_P = 3'h5;
  localparam logic [2:0] WR_P = 3'h6;
  localparam logic [2:0] AL_P = 3'h1;
  localparam logic [2:0] CWL_P = 3'h3;
  localparam logic [31:0] RST0 = (32'(AL_P) << 19) | (32'(WR_P) << 9) | (32'(CL_P) << 4);
  localparam logic [31:0] RST1 = 32'(CWL_P) << 3;
  typedef struct packed {logic [9:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] addr;
  logic cs, wr, rd, waitreq;
  logic [31:0] wdata, rdata, rv;
  logic cal_ok = 1'b0;
  logic cal_fail = 1'b0;
  logic cal_req, mrs_valid;
  logic mrs_ready = 1'b0;
  mrs_cmd_t mrs_cmd;
  mrs_cmd_t cmds[$];
  mrs_cmd_t exp_cmd [4] = '{'{2'h2, 16'h0038}, '{2'h3, 16'h0001}, '{2'h1, 16'h0028}, '{2'h0, 16'h0B50}};
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // fixed bits, reserved bits, writable fields, unmapped places
  row_t rows [8] = '{
    '{ADDR_MODE01, 32'hFFFFFFFF, 32'h1FFF0F70},
    '{ADDR_MODE01, 32'h00000000, 32'h00000000},
    '{ADDR_MODE23, 32'hFFFFFFFF, 32'h000706F8},
    '{ADDR_MODE23, 32'h00000000, 32'h00000000},
    '{10'h126, 32'hFFFFFFFF, 32'h00000000},
    '{10'h3FF, 32'h12345678, 32'h00000000},
    '{ADDR_MODE01, 32'hE0287B5F, 32'h00280B50},
    '{ADDR_MODE23, 32'hFFF9F93F, 32'h00010038}};

  always #20 mclk = ~mclk;

  ddr3_mode_register_shadow #(.CAS_LATENCY(CL_P), .WRITE_RECOVERY(WR_P), .ADDITIVE_LATENCY(AL_P),
    .CAS_WRITE_LATENCY(CWL_P)) dut_u (.MCLK_I(mclk), .RESETN_I(resetn), .DBG_ADDR_I(addr),
    .DBG_CS_I(cs), .DBG_WR_I(wr), .DBG_WR_DATA_I(wdata), .DBG_RD_I(rd), .DBG_RD_DATA_O(rdata),
    .DBG_WAITREQUEST_O(waitreq), .CAL_SUCCESS_I(cal_ok), .CAL_FAIL_I(cal_fail), .CAL_REQ_O(cal_req),
    .MRS_READY_I(mrs_ready), .MRS_VALID_O(mrs_valid), .MRS_CMD_O(mrs_cmd));

  host_model host_u (.clk_i(mclk), .addr_o(addr), .cs_o(cs), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
    .rdata_i(rdata), .wait_i(waitreq));

  // command sink stalls every other cycle
  always @(posedge mclk)
  begin
    mrs_ready <= ~mrs_ready;
    if (mrs_valid === 1'b1 && mrs_ready === 1'b1)
      cmds.push_back(mrs_cmd);
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (20) @(posedge mclk);
    chk(32'(cal_req), 32'h0);
    chk(32'(mrs_valid), 32'h0);
    resetn <= 1'b1;
    host_u.bus_rd(ADDR_MODE01, rv);
    chk(rv, RST0);
    host_u.bus_rd(ADDR_MODE23, rv);
    chk(rv, RST1);
    foreach (rows[i])
    begin
      host_u.bus_wr(rows[i].a, rows[i].d);
      host_u.bus_rd(rows[i].a, rv);
      chk(rv, rows[i].e);
    end
    // timing register mirror lies outside this block; write is dropped
    host_u.bus_wr(10'h126, 32'h00000ABC);
    host_u.bus_wr(ADDR_CALCTL, 32'h00000004);
    @(posedge mclk);
    chk(32'(cal_req), 32'h1);
    host_u.bus_rd(ADDR_CALCTL, rv);
    chk(rv, 32'h00000004);
    host_u.bus_wr(ADDR_CALCTL, 32'h00000000);
    @(posedge mclk);
    chk(32'(cal_req), 32'h0);
    for (int i = 0; i < 8 && mrs_valid !== 1'b1; i++)
      @(posedge mclk);
    // a write during issue must stall until all four commands are out
    host_u.bus_wr(ADDR_MODE23, 32'h00000000);
    chk(32'(cmds.size()), 32'h4);
    foreach (exp_cmd[i])
      chk(32'(cmds[i]), 32'(exp_cmd[i]));
    chk(32'(mrs_valid), 32'h0);
    host_u.bus_rd(ADDR_MODE23, rv);
    chk(rv, 32'h0);
    for (int s = 1; s < 3; s++)
    begin
      cal_ok <= s[0];
      cal_fail <= s[1];
      // status is read only once the phy reports a result
      @(posedge mclk);
      host_u.bus_wr(ADDR_CALCTL, 32'hFFFFFFFB);
      host_u.bus_rd(ADDR_CALCTL, rv);
      chk(rv, 32'(s));
    end
    // second reset in mid-run restores the generated values
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    host_u.bus_rd(ADDR_MODE01, rv);
    chk(rv, RST0);
    host_u.bus_rd(ADDR_MODE23, rv);
    chk(rv, RST1);
    chk(32'(cal_req), 32'h0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
